//--- design/flash_pkg.sv
// shared constants and types for the serial flash device and its controller
// assumes both ends run on clk_sys at 250 MHz and meet over flash_link
package flash_pkg;

  // clock and serial timing
  localparam int CLK_NS = 4;
  localparam int SCLK_NS = 48;
  localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_NS / (2 * CLK_NS));
  localparam int BUSY_NS = 400;
  localparam logic [7:0] BUSY_CYC = 8'(BUSY_NS / CLK_NS);

  // array geometry
  localparam int ADDR_W = 24;
  localparam int BLOCKS = 128;
  localparam logic [6:0] TOP_BLOCK = 7'h7f;
  localparam int LOCK_BITS = 160;
  localparam logic [7:0] LOCK_LO_BASE = 8'h80;
  localparam logic [7:0] LOCK_HI_BASE = 8'h90;
  localparam logic [8:0] OTP_ESN_LAST = 9'h00f;

  // command codes
  localparam logic [7:0] OPC_WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] OPC_PP = 8'h02;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_SE = 8'h20;
  localparam logic [7:0] OPC_RDSCUR = 8'h2b;
  localparam logic [7:0] OPC_WRITE_SECURITY_REG_CMD = 8'h2f;
  localparam logic [7:0] OPC_SBLK = 8'h36;
  localparam logic [7:0] OPC_SBULK = 8'h39;
  localparam logic [7:0] OPC_CE = 8'h60;
  localparam logic [7:0] OPC_ENTER_OTP_MODE_CMD = 8'hb1;
  localparam logic [7:0] OPC_EXIT_OTP_MODE_CMD = 8'hc1;
  localparam logic [7:0] OPC_BE = 8'hd8;

  // status and security register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_TB = 6;
  localparam int SCUR_FACTORY = 0;
  localparam int SCUR_CUST = 1;

  // array operation kinds handed to the storage
  localparam logic [1:0] OP_PROG = 2'h0;
  localparam logic [1:0] OP_SECTOR = 2'h1;
  localparam logic [1:0] OP_BLOCK = 2'h2;
  localparam logic [1:0] OP_CHIP = 2'h3;

  // controller register offsets and control fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CTRL_HAS_ADDR = 8;
  localparam int CTRL_SEND_DATA = 9;
  localparam int CTRL_READ_BYTE = 10;
  localparam int CTRL_START = 11;

  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_CMD = 4'b0010,
    D_ACT = 4'b0100,
    D_STBY = 4'b1000
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SHIFT = 3'b010,
    H_GAP = 3'b100
  } host_state_t;

endpackage

//--- design/flash_link.sv
// serial link between the flash controller and the flash device
// assumes the data output line idles high when the device does not drive it
`timescale 1ns/1ns
`default_nettype none
interface flash_link;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // resolved output line: released line reads as pulled high
  assign so_line = so_oe ? so : 1'b1;

  modport dev (input cs_n, input sclk, input si, output so, output so_oe);
  modport host (output cs_n, output sclk, output si, input so_line);
endinterface
`default_nettype wire

//--- design/flash_dev.sv
// serial flash device: command decode, protection, otp and lock logic
// assumes storage outside answers rd_data one cycle after rd_addr changes
// and performs each op pulse; link pins come from another clock domain
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - bottom select: levels 1-7 guard lowest blocks
// - levels 8 to 15 guard all blocks
// - chip erase only with level zero
// - 4K-bit otp; security bit 0 factory lock
// - host enters otp, programs, then exits
// - security write sets customer lock bit 1
// - locked otp part and lock bit frozen
// - otp mode hides the main array
// - otp bytes 0-F serial, 10-1FF customer
// - 8M bytes in 4K sectors, 2048
// - end blocks lock per sector, others per block
// - host reads status before each command
// - bad opcode: standby, output released, until select
// - good opcode: active until select rises; read while busy: standby
// - sample on sclk rise, shift on fall
// - read types stream data, stop anywhere
// - write types need byte boundary at end
// - array access ignored while busy
// - top select: levels 1-7 guard highest blocks
// - write latch needed; cleared after each write
module flash_dev (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  flash_link.dev link,
  input wire logic factory_lock_in,
  output logic [flash_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_otp,
  input wire logic [7:0] rd_data,
  output logic op_valid,
  output logic [1:0] op_kind,
  output logic [flash_pkg::ADDR_W-1:0] op_addr,
  output logic [7:0] op_data,
  output logic op_otp
);
  import flash_pkg::*;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sclk_s;
    logic [1:0] si_s;
    dev_state_t st;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [7:0] opc;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic so;
    logic so_oe;
    logic write_enable_latch;
    logic [3:0] level;
    logic tb;
    logic otp_mode;
    logic cust_lock;
    logic fact_lock;
    logic [1:0] fact_s;
    logic [7:0] busy_cnt;
    logic [LOCK_BITS-1:0] locks;
    logic [ADDR_W-1:0] rd_addr;
    logic op_valid;
    logic [1:0] op_kind;
    logic [ADDR_W-1:0] op_addr;
    logic [7:0] op_data;
    logic op_otp;
  } dev_regs_t;

  dev_regs_t q, n;
  logic [7:0] b;
  logic [7:0] src;
  logic busy;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic rd_phase;
  logic wr_ok;

  // level-based guard of one 64K block
  function automatic logic level_prot(input logic [3:0] lvl, input logic tb,
                                      input logic [6:0] blk);
    logic [7:0] cnt;
    cnt = 8'h01 << (lvl - 4'h1);
    if (lvl[3]) return 1'b1;
    if (lvl == 4'h0) return 1'b0;
    if (tb) return {1'b0, blk} < cnt;
    return {1'b0, blk} >= (8'(BLOCKS) - cnt);
  endfunction

  // lock bit index: end blocks split into 16 sectors each
  function automatic logic [7:0] lock_idx(input logic [ADDR_W-1:0] a);
    if (a[22:16] == 7'h00) return LOCK_LO_BASE + {4'h0, a[15:12]};
    if (a[22:16] == TOP_BLOCK) return LOCK_HI_BASE + {4'h0, a[15:12]};
    return {1'b0, a[22:16]};
  endfunction

  // whole-block lock test, any sector lock counts for an end block
  function automatic logic block_locked(input logic [LOCK_BITS-1:0] lk,
                                        input logic [6:0] blk);
    if (blk == 7'h00) return |lk[LOCK_LO_BASE +: 16];
    if (blk == TOP_BLOCK) return |lk[LOCK_HI_BASE +: 16];
    return lk[blk];
  endfunction

  assign busy = q.busy_cnt != 8'h00;
  assign cs_rise = q.cs_s[1] && !q.cs_s[2];
  assign cs_fall = !q.cs_s[1] && q.cs_s[2];
  assign sclk_rise = q.sclk_s[1] && !q.sclk_s[2];
  assign sclk_fall = !q.sclk_s[1] && q.sclk_s[2];
  assign b = {q.shin[6:0], q.si_s[1]};
  assign wr_ok = q.write_enable_latch && !busy;
  // read types stream from the byte after opcode or address
  assign rd_phase = ((q.opc == OPC_RDSR || q.opc == OPC_RDSCUR)
                     && q.byte_cnt != 3'd0)
                    || (q.opc == OPC_READ && q.byte_cnt >= 3'd4);

  // source byte for the next output byte
  always_comb begin
    src = rd_data;
    if (q.opc == OPC_RDSR) begin
      src = {1'b0, q.tb, q.level, q.write_enable_latch, busy};
    end else if (q.opc == OPC_RDSCUR) begin
      src = {6'h00, q.cust_lock, q.fact_lock};
    end
  end

  // next-state logic for the whole device
  always_comb begin
    n = q;
    n.op_valid = 1'b0;
    n.cs_s = {q.cs_s[1:0], link.cs_n};
    n.sclk_s = {q.sclk_s[1:0], link.sclk};
    n.si_s = {q.si_s[0], link.si};
    if (busy) begin
      n.busy_cnt = q.busy_cnt - 8'h01;
    end
    // strap comes from a pin: two flops first; once seen it holds until reset
    n.fact_s = {q.fact_s[0], factory_lock_in};
    if (q.fact_s[1]) n.fact_lock = 1'b1;
    if (cs_rise) begin
      n.st = D_IDLE;
      n.so_oe = 1'b0;
      // write types act only when select rises on a byte boundary
      if (q.st == D_ACT && q.bit_cnt == 3'd0) begin
        unique case (q.opc)
          OPC_WRITE_ENABLE_CMD: n.write_enable_latch = 1'b1;
          OPC_WRDI: n.write_enable_latch = 1'b0;
          OPC_WRITE_STATUS_CMD: begin
            if (wr_ok && q.byte_cnt >= 3'd2) begin
              n.level = q.data[ST_LEVEL_LSB +: 4];
              n.tb = q.data[ST_TB];
              n.write_enable_latch = 1'b0;
              n.busy_cnt = BUSY_CYC;
            end
          end
          OPC_PP: begin
            if (wr_ok && q.byte_cnt >= 3'd5) begin
              n.write_enable_latch = 1'b0;
              if (q.otp_mode) begin
                // serial part under factory lock, rest under customer
                if ((q.addr[8:0] <= OTP_ESN_LAST) ? !q.fact_lock
                                                   : !q.cust_lock) begin
                  n.op_valid = 1'b1;
                end
              end else if (!level_prot(q.level, q.tb, q.addr[22:16])
                           && !q.locks[lock_idx(q.addr)]) begin
                n.op_valid = 1'b1;
              end
              n.op_kind = OP_PROG;
            end
          end
          OPC_SE, OPC_BE: begin
            if (wr_ok && q.byte_cnt >= 3'd4) begin
              n.write_enable_latch = 1'b0;
              n.op_kind = (q.opc == OPC_SE) ? OP_SECTOR : OP_BLOCK;
              if (!q.otp_mode && !level_prot(q.level, q.tb, q.addr[22:16])
                  && !((q.opc == OPC_SE) ? q.locks[lock_idx(q.addr)]
                       : block_locked(q.locks, q.addr[22:16]))) begin
                n.op_valid = 1'b1;
              end
            end
          end
          OPC_CE: begin
            if (wr_ok) begin
              n.write_enable_latch = 1'b0;
              n.op_kind = OP_CHIP;
              if (q.level == 4'h0 && !q.otp_mode) n.op_valid = 1'b1;
            end
          end
          OPC_ENTER_OTP_MODE_CMD: n.otp_mode = 1'b1;
          OPC_EXIT_OTP_MODE_CMD: n.otp_mode = 1'b0;
          OPC_WRITE_SECURITY_REG_CMD: begin
            if (wr_ok) begin
              n.cust_lock = 1'b1;
              n.write_enable_latch = 1'b0;
            end
          end
          OPC_SBLK, OPC_SBULK: begin
            if (wr_ok && q.byte_cnt >= 3'd4) begin
              n.locks[lock_idx(q.addr)] = (q.opc == OPC_SBLK);
              n.write_enable_latch = 1'b0;
            end
          end
          default: n.write_enable_latch = q.write_enable_latch;
        endcase
        if (n.op_valid) begin
          n.op_addr = q.addr;
          n.op_data = q.data;
          n.op_otp = q.otp_mode;
          n.busy_cnt = BUSY_CYC;
        end
      end
    end else if (cs_fall) begin
      n.st = D_CMD;
      n.bit_cnt = 3'd0;
      n.byte_cnt = 3'd0;
      n.so_oe = 1'b0;
    end else if (q.st == D_CMD || q.st == D_ACT) begin
      if (sclk_rise) begin
        // input bits taken on the rising edge
        n.shin = b;
        n.bit_cnt = q.bit_cnt + 3'd1;
        if (q.bit_cnt == 3'd7) begin
          if (q.byte_cnt != 3'd7) n.byte_cnt = q.byte_cnt + 3'd1;
          if (q.byte_cnt == 3'd0) begin
            n.opc = b;
            unique case (b)
              OPC_WRITE_STATUS_CMD, OPC_PP, OPC_WRDI, OPC_RDSR, OPC_WRITE_ENABLE_CMD, OPC_SE,
              OPC_RDSCUR, OPC_WRITE_SECURITY_REG_CMD, OPC_SBLK, OPC_SBULK, OPC_CE,
              OPC_ENTER_OTP_MODE_CMD, OPC_EXIT_OTP_MODE_CMD, OPC_BE: n.st = D_ACT;
              OPC_READ: n.st = busy ? D_STBY : D_ACT;
              default: n.st = D_STBY;
            endcase
          end else begin
            if (q.byte_cnt <= 3'd3) n.addr = {q.addr[15:0], b};
            if (q.opc != OPC_WRITE_STATUS_CMD || q.byte_cnt == 3'd1) n.data = b;
            if (q.byte_cnt == 3'd3) n.rd_addr = {q.addr[15:0], b};
          end
        end
      end else if (sclk_fall && q.st == D_ACT && rd_phase) begin
        // output bits change on the falling edge
        n.so_oe = 1'b1;
        if (q.bit_cnt == 3'd0) begin
          n.so = src[7];
          n.shout = {src[6:0], 1'b0};
          if (q.opc == OPC_READ) begin
            n.rd_addr = q.rd_addr + 24'h00_0001;
          end
        end else begin
          n.so = q.shout[7];
          n.shout = {q.shout[6:0], 1'b0};
        end
      end
    end
  end

  // all state registered here; ce low freezes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.cs_s <= 3'h7;
      q.st <= D_IDLE;
    end else if (ce) begin
      q <= n;
    end
  end

  assign link.so = q.so;
  assign link.so_oe = q.so_oe;
  assign rd_addr = q.rd_addr;
  assign rd_otp = q.otp_mode;
  assign op_valid = q.op_valid;
  assign op_kind = q.op_kind;
  assign op_addr = q.op_addr;
  assign op_data = q.op_data;
  assign op_otp = q.op_otp;
endmodule
`default_nettype wire

//--- design/flash_host.sv
// serial flash controller: one framed transfer per software request
// assumes software orders commands (status polling, otp entry and exit)
`timescale 1ns/1ns
`default_nettype none
module flash_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  flash_link.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import flash_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [1:0] so_s;
    logic [3:0] div;
    logic [5:0] cnt;
    logic [5:0] nbits;
    logic [39:0] tx;
    logic [7:0] rx;
    logic sclk;
    logic cs_n;
    logic [11:0] ctrl;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;
  } host_regs_t;

  host_regs_t q, n;
  logic [39:0] frame;
  logic [3:0] full;

  assign full = {SCLK_HALF_CYC[2:0], 1'b0};

  // frame bits, left aligned: opcode, optional address, optional data
  always_comb begin
    frame = {reg_wdata[7:0], 32'h0000_0000};
    if (reg_wdata[CTRL_HAS_ADDR]) begin
      frame[31:8] = q.addr;
      frame[7:0] = q.wdata;
    end else begin
      frame[31:24] = q.wdata;
    end
  end

  // register access and serial sequencing
  always_comb begin
    n = q;
    n.so_s = {q.so_s[0], link.so_line};
    n.rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: n.rdata = {20'h0_0000, q.ctrl};
        REG_ADDR: n.rdata = {8'h00, q.addr};
        REG_WDATA: n.rdata = {24'h00_0000, q.wdata};
        REG_STATUS: n.rdata = {16'h0000, q.rx, 7'h00, q.st != H_IDLE};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr && q.st == H_IDLE) begin
      if (reg_addr == REG_ADDR) n.addr = reg_wdata[ADDR_W-1:0];
      if (reg_addr == REG_WDATA) n.wdata = reg_wdata[7:0];
      if (reg_addr == REG_CTRL) begin
        n.ctrl = {1'b0, reg_wdata[10:0]};
        if (reg_wdata[CTRL_START]) begin
          n.st = H_SHIFT;
          n.cs_n = 1'b0;
          n.tx = frame;
          n.div = 4'h0;
          n.cnt = 6'h00;
          n.nbits = 6'd8 + (reg_wdata[CTRL_HAS_ADDR] ? 6'd24 : 6'd0)
                    + (reg_wdata[CTRL_SEND_DATA] ? 6'd8 : 6'd0)
                    + (reg_wdata[CTRL_READ_BYTE] ? 6'd8 : 6'd0);
        end
      end
    end
    unique case (q.st)
      H_IDLE: n.sclk = 1'b0;
      H_SHIFT: begin
        n.div = q.div + 4'h1;
        if (q.div == SCLK_HALF_CYC - 4'h1) begin
          n.sclk = 1'b1;
        end
        // sample late in the high phase, after the device output settled
        if (q.div == full - 4'h2) begin
          n.rx = {q.rx[6:0], q.so_s[1]};
        end
        if (q.div == full - 4'h1) begin
          n.sclk = 1'b0;
          n.div = 4'h0;
          n.cnt = q.cnt + 6'h01;
          n.tx = {q.tx[38:0], 1'b0};
          // select rises only after a whole number of bytes
          if (q.cnt + 6'h01 == q.nbits) begin
            n.cs_n = 1'b1;
            n.st = H_GAP;
          end
        end
      end
      H_GAP: begin
        n.div = q.div + 4'h1;
        if (q.div == full - 4'h1) begin
          n.div = 4'h0;
          n.st = H_IDLE;
        end
      end
    endcase
  end

  // single state register; ce low freezes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= H_IDLE;
      q.cs_n <= 1'b1;
      q.so_s <= 2'h3;
    end else if (ce) begin
      q <= n;
    end
  end

  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.si = q.tx[39];
  assign reg_rdata = q.rdata;
endmodule
`default_nettype wire

//--- verification/flash_link_props.sv
// checker for the serial link between the flash controller and device
// assumes it sits beside the link and sees its signals by name
`timescale 1ns/1ns
`default_nettype none
module flash_link_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  import flash_pkg::*;

  logic sclk_q;
  logic [2:0] bits_q;
  logic [7:0] opc_q;
  logic [3:0] nbit_q;
  logic bad_opc;

  // clock rises per frame; a frame may only end on a whole byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'h0;
      bits_q <= 3'h0;
      opc_q <= 8'h00;
      nbit_q <= 4'h0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) bits_q <= 3'h0;
      else if (sclk && !sclk_q) bits_q <= bits_q + 3'h1;
      // first byte of the frame kept to spot an unknown opcode
      if (cs_n) begin
        nbit_q <= 4'h0;
      end else if (sclk && !sclk_q && nbit_q != 4'h8) begin
        opc_q <= {opc_q[6:0], si};
        nbit_q <= nbit_q + 4'h1;
      end
    end
  end

  // anything outside the decoded set sends the device to standby
  assign bad_opc = nbit_q == 4'h8 && !(opc_q inside {OPC_WRITE_STATUS_CMD, OPC_PP,
    OPC_READ, OPC_WRDI, OPC_RDSR, OPC_WRITE_ENABLE_CMD, OPC_SE, OPC_RDSCUR, OPC_WRITE_SECURITY_REG_CMD,
    OPC_SBLK, OPC_SBULK, OPC_CE, OPC_ENTER_OTP_MODE_CMD, OPC_EXIT_OTP_MODE_CMD, OPC_BE});

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("serial clock not low while deselected");
  byte_end_a: assert property ($rose(cs_n) |-> bits_q == 3'h0)
    else $error("frame ended off a byte boundary");
  stby_out_a: assert property (bad_opc && !cs_n |-> so_line && !so_oe)
    else $error("output driven after an unknown opcode");
  select_release_a: assert property (cs_n [*6] |-> !so_oe)
    else $error("output still driven after deselect");
  clock_high_a: assert property (
    $rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("serial clock high phase not six cycles");
  input_hold_a: assert property (sclk && $past(sclk) |-> $stable(si))
    else $error("input bit moved while clock high");
  output_hold_a: assert property (
    so_oe && sclk && $past(sclk) |-> $stable(so))
    else $error("output bit moved while clock high");
  drive_select_a: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output driven outside a frame");
  select_lead_a: assert property ($fell(cs_n) |-> !sclk [*4])
    else $error("clock rose too soon after select");
endmodule
`default_nettype wire

//--- verification/serial_flash_protect_otp_ops_tb.sv
// bench: controller and flash device joined over the link
// assumes a one-cycle storage model behind the device read port
`timescale 1ns/1ns
`default_nettype none
module serial_flash_protect_otp_ops_tb;
  import flash_pkg::*;
  typedef struct packed {
    logic tb;
    logic [3:0] lvl;
    logic [7:0] opc;
    logic [23:0] adr;
    logic go;
  } row_t;
  // protect level, target and whether an array operation must follow
  localparam row_t ROWS [20] = '{
    '{1'h1, 4'h1, OPC_SE, 24'h00_0000, 1'h0},
    '{1'h1, 4'h1, OPC_SE, 24'h01_0000, 1'h1},
    '{1'h1, 4'h7, OPC_BE, 24'h3f_0000, 1'h0},
    '{1'h1, 4'h7, OPC_BE, 24'h40_0000, 1'h1},
    '{1'h0, 4'h1, OPC_SE, 24'h7f_f000, 1'h0},
    '{1'h0, 4'h1, OPC_SE, 24'h7e_0000, 1'h1},
    '{1'h0, 4'h7, OPC_SE, 24'h40_0000, 1'h0},
    '{1'h0, 4'h7, OPC_SE, 24'h3f_f000, 1'h1},
    '{1'h0, 4'h8, OPC_SE, 24'h00_0000, 1'h0},
    '{1'h1, 4'hf, OPC_PP, 24'h7f_ffff, 1'h0},
    '{1'h1, 4'h1, OPC_CE, 24'h00_0000, 1'h0},
    '{1'h0, 4'h0, OPC_CE, 24'h00_0000, 1'h1},
    '{1'h0, 4'h0, OPC_PP, 24'h00_0100, 1'h1},
    '{1'h0, 4'h0, OPC_SBLK, 24'h00_1000, 1'h0},
    '{1'h0, 4'h0, OPC_SE, 24'h00_1000, 1'h0},
    '{1'h0, 4'h0, OPC_SE, 24'h00_2000, 1'h1},
    '{1'h0, 4'h0, OPC_SBLK, 24'h02_0000, 1'h0},
    '{1'h0, 4'h0, OPC_SE, 24'h02_f000, 1'h0},
    '{1'h0, 4'h0, OPC_SBULK, 24'h00_1000, 1'h0},
    '{1'h0, 4'h0, OPC_SE, 24'h00_1000, 1'h1}};
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic factory_lock = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic [23:0] rd_addr, op_addr, op_a;
  logic rd_otp, op_valid, op_otp, op_o;
  logic [7:0] rd_data = 8'h00;
  logic [1:0] op_kind, op_k;
  logic [7:0] op_data, op_d, st, b;
  int mismatches = 0;
  int check_count = 0;
  int op_cnt = 0;

  always #2 clk_sys = ~clk_sys;

  flash_link link ();
  flash_dev u_flash_dev (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'h1),
    .link(link), .factory_lock_in(factory_lock), .rd_addr(rd_addr),
    .rd_otp(rd_otp), .rd_data(rd_data), .op_valid(op_valid),
    .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
    .op_otp(op_otp));
  flash_host u_flash_host (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'h1),
    .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  flash_link_props u_flash_link_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so),
    .so_oe(link.so_oe), .so_line(link.so_line));

  // storage answers a cycle late; otp bytes differ so a wrong area shows
  always @(posedge clk_sys) begin
    rd_data <= rd_addr[7:0] ^ (rd_otp ? 8'h5a : 8'h00);
    if (op_valid === 1'h1) begin
      op_cnt <= op_cnt + 1;
      op_k <= op_kind;
      op_o <= op_otp;
      op_d <= op_data;
      op_a <= op_addr;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // register strobes; a spare edge keeps each strobe one cycle long
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  function automatic logic [31:0] ctrl_of(input logic [7:0] o);
    logic [2:0] f;
    case (o)
      OPC_PP: f = 3'h3;
      OPC_SE, OPC_BE, OPC_SBLK, OPC_SBULK: f = 3'h1;
      OPC_READ: f = 3'h5;
      OPC_WRITE_STATUS_CMD: f = 3'h2;
      OPC_WRITE_ENABLE_CMD, OPC_CE, OPC_ENTER_OTP_MODE_CMD, OPC_EXIT_OTP_MODE_CMD, OPC_WRITE_SECURITY_REG_CMD: f = 3'h0;
      default: f = 3'h4;
    endcase
    return {20'h0_0000, 1'h1, f, o};
  endfunction

  function automatic logic [1:0] kind_of(input logic [7:0] o);
    case (o)
      OPC_PP: return OP_PROG;
      OPC_SE: return OP_SECTOR;
      OPC_BE: return OP_BLOCK;
      default: return OP_CHIP;
    endcase
  endfunction

  // one framed transfer; hands back the last byte received
  task automatic cmd(input logic [7:0] o, input logic [23:0] a,
                     input logic [7:0] wd, output logic [7:0] rx);
    logic [31:0] s;
    wr(REG_ADDR, {8'h00, a});
    wr(REG_WDATA, {24'h00_0000, wd});
    wr(REG_CTRL, ctrl_of(o));
    s = 32'h0000_0001;
    for (int i = 0; i < 400 && s[0] !== 1'h0; i++) rd(REG_STATUS, s);
    rx = s[15:8];
  endtask

  task automatic ready(output logic [7:0] s);
    s = 8'h01;
    for (int i = 0; i < 20 && s[0] !== 1'h0; i++)
      cmd(OPC_RDSR, 24'h00_0000, 8'h00, s);
  endtask

  // write-type command behind a fresh enable, counting array operations
  task automatic wop(input logic [7:0] o, input logic [23:0] a,
                     input logic [7:0] wd, input int go);
    int n;
    n = op_cnt;
    cmd(OPC_WRITE_ENABLE_CMD, 24'h00_0000, 8'h00, b);
    cmd(o, a, wd, b);
    // poll until idle so the next command meets a ready device
    ready(st);
    chk(st[ST_BUSY], 1'h0);
    chk(op_cnt - n, go);
    chk(st[ST_WEL], 1'h0);
  endtask

  initial begin
    #400_000;
    mismatches++;
    end_sim();
  end

  initial begin
    row_t r;
    int n;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (int i = 0; i < 20; i++) begin
      r = ROWS[i];
      wop(OPC_WRITE_STATUS_CMD, 24'h00_0000, {1'h0, r.tb, r.lvl, 2'h0}, 0);
      chk(st[6:2], {r.tb, r.lvl});
      wop(r.opc, r.adr, 8'ha5, r.go);
      if (r.go) chk(op_k, kind_of(r.opc));
      if (r.go && r.opc != OPC_CE) chk(op_a, r.adr);
    end
    // short read, then an unknown opcode must leave the line released
    cmd(OPC_READ, 24'h12_3456, 8'h00, b);
    chk(b, 8'h56);
    cmd(8'h77, 24'h00_0000, 8'h00, b);
    chk(b, 8'hff);
    n = op_cnt;
    cmd(OPC_SE, 24'h30_0000, 8'h00, b);
    ready(st);
    chk(op_cnt - n, 0);
    // otp area: reads and programs go there, array erase is refused
    cmd(OPC_ENTER_OTP_MODE_CMD, 24'h00_0000, 8'h00, b);
    cmd(OPC_READ, 24'h00_0010, 8'h00, b);
    chk(b, 8'h4a);
    wop(OPC_PP, 24'h00_0010, 8'ha5, 1);
    chk({op_o, op_d}, 9'h1a5);
    wop(OPC_SE, 24'h00_0000, 8'h00, 0);
    wop(OPC_WRITE_SECURITY_REG_CMD, 24'h00_0000, 8'h00, 0);
    cmd(OPC_RDSCUR, 24'h00_0000, 8'h00, b);
    chk(b, 8'h02);
    wop(OPC_PP, 24'h00_0020, 8'ha5, 0);
    wop(OPC_PP, 24'h00_0005, 8'ha5, 1);
    cmd(OPC_EXIT_OTP_MODE_CMD, 24'h00_0000, 8'h00, b);
    cmd(OPC_READ, 24'h00_0010, 8'h00, b);
    chk(b, 8'h10);
    // second reset in mid-run, now with the factory lock strapped
    rst_n <= 1'h0;
    factory_lock <= 1'h1;
    @(negedge clk_sys);
    chk({link.cs_n, link.sclk, link.so_oe}, 3'h4);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    cmd(OPC_RDSR, 24'h00_0000, 8'h00, b);
    chk(b, 8'h00);
    cmd(OPC_RDSCUR, 24'h00_0000, 8'h00, b);
    chk(b, 8'h01);
    cmd(OPC_ENTER_OTP_MODE_CMD, 24'h00_0000, 8'h00, b);
    wop(OPC_PP, 24'h00_0003, 8'ha5, 0);
    wop(OPC_PP, 24'h00_0100, 8'ha5, 1);
    end_sim();
  end
endmodule
`default_nettype wire
